// ===== verilog/pin_mux_pkg.sv
// Constants for the timer and serial pin multiplexer.
// Function
// - Remap bit 7 puts channel four output on B4.
// - Channel four capture follows remap bit 7.
// - Remap bit 4 clear: channel one on A0.
// - Remap bit 6 clear: channel three on A1.
// - Remap bit 5 clear: channel two on A3.
// - Timer drives only when enabled and alternate selected.
// - Four-bit config field picks each pin's function.
// - Ready-to-send owns B4 only without channel four.
// - Serial two owns A pins only without timer.
// - Ready-to-send needs config bit 5 and UART.
// - SPI config bit 4 selects master or slave.
// - A1 slave data out, master data in.
// - Two-wire pins use open-drain alternate output.
// - Mode selects which protocol reaches the pins.
// - Trace clock on A3 under three conditions.
package pin_mux_pkg;
   // ******************************************************************
   // Pin indices within the pad vectors.
   // ******************************************************************
   localparam int PIN_A0 = 0;
   localparam int PIN_A1 = 1;
   localparam int PIN_A2 = 2;
   localparam int PIN_A3 = 3;
   localparam int PIN_B4 = 4;
   localparam int PIN_COUNT = 5;
   // ******************************************************************
   // Remap option bits and config field positions.
   // ******************************************************************
   localparam int REMAP_CH1 = 4;
   localparam int REMAP_CH2 = 5;
   localparam int REMAP_CH3 = 6;
   localparam int REMAP_CH4 = 7;
   localparam int FIELD_A0_LSB = 0;
   localparam int FIELD_A1_LSB = 4;
   localparam int FIELD_A2_LSB = 8;
   localparam int FIELD_A3_LSB = 12;
   localparam int FIELD_B4_LSB = 0;
   localparam int FIELD_WIDTH = 4;
   localparam int UART_RTS_ENABLE_BIT = 5;
   localparam int SPI_MASTER_BIT = 4;
   // ******************************************************************
   // Pin config field encodings.
   // ******************************************************************
   localparam logic [3:0] CFG_GPIO_OUT = 4'h1;
   localparam logic [3:0] CFG_GPIO_OPEN_DRAIN = 4'h5;
   localparam logic [3:0] CFG_ALT_OUT = 4'h9;
   localparam logic [3:0] CFG_ALT_OPEN_DRAIN = 4'hd;
   // ******************************************************************
   // Serial controller protocol selections.
   // ******************************************************************
   typedef enum logic [1:0]
   {
      PROTOCOL_OFF = 2'h0,
      PROTOCOL_UART = 2'h1,
      PROTOCOL_SPI = 2'h2,
      PROTOCOL_TWO_WIRE = 2'h3
   } protocol_t;
   // ******************************************************************
   // Reset values.
   // ******************************************************************
   localparam logic [4:0] RESET_PAD_OUT = 5'h00;
   localparam logic [4:0] RESET_PAD_OE_N = 5'h1f;
   localparam logic [3:0] RESET_CAPTURE = 4'h0;
endpackage

// ===== verilog/timer_serial_pin_mux.sv
// Pin multiplexer for timer two, serial controllers one and two and trace clock.
`timescale 1ns/1ps
module timer_serial_pin_mux
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [7:0] TIMER2_REMAP_OPTION,
   input wire logic [3:0] TIMER2_CHANNEL_OUTPUT_ENABLE,
   input wire logic [3:0] PORTB_HIGH_PIN_CONFIG,
   input wire logic [15:0] PORTA_LOW_PIN_CONFIG,
   input wire logic [7:0] SERIAL1_UART_CONFIG,
   input wire logic [1:0] SERIAL1_PROTOCOL_SELECT,
   input wire logic [1:0] SERIAL2_PROTOCOL_SELECT,
   input wire logic [7:0] SERIAL1_SPI_CONFIG,
   input wire logic [7:0] SERIAL2_SPI_CONFIG,
   input wire logic CPU_TRACE_ENABLE,
   input wire logic CPU_TRACE_CLOCK,
   input wire logic [3:0] TIMER2_CHANNEL_OUT,
   input wire logic [3:0] TIMER2_REMAPPED_CAPTURE_IN,
   output logic [3:0] TIMER2_CAPTURE_IN,
   input wire logic SERIAL1_READY_TO_SEND_N,
   output logic SERIAL1_SLAVE_SELECT_N,
   input wire logic SERIAL2_MASTER_OUT,
   output logic SERIAL2_SLAVE_IN,
   input wire logic SERIAL2_SLAVE_OUT,
   output logic SERIAL2_MASTER_IN,
   input wire logic SERIAL2_TWOWIRE_DATA_OUT,
   output logic SERIAL2_TWOWIRE_DATA_IN,
   input wire logic SERIAL2_TWOWIRE_CLOCK_OUT,
   output logic SERIAL2_TWOWIRE_CLOCK_IN,
   input wire logic SERIAL2_SPI_CLOCK_OUT,
   output logic SERIAL2_SPI_CLOCK_IN,
   output logic SERIAL2_SLAVE_SELECT_N,
   input wire logic [4:0] GPIO_OUT_DATA,
   output logic [4:0] GPIO_IN_DATA,
   input wire logic [4:0] PAD_IN,
   output logic [4:0] PAD_OUT,
   output logic [4:0] PAD_OE_N
);
   // ******************************************************************
   // Helpers.
   // ******************************************************************
   function automatic logic is_alt(input logic [3:0] field);
      is_alt = (field == pin_mux_pkg::CFG_ALT_OUT) || (field == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
   endfunction

   // Open drain only pulls low; a high level is left to the board pull-up.
   function automatic logic [1:0] drive(input logic value, input logic open_drain);
      drive = open_drain ? {1'b0, value} : {value, 1'b0};
   endfunction

   logic [3:0] field_a0;
   logic [3:0] field_a1;
   logic [3:0] field_a2;
   logic [3:0] field_a3;
   logic [3:0] field_b4;
   logic [3:0] timer_here;
   logic ch4_on_b4;
   logic s1_uart;
   logic s1_spi_slave;
   logic s2_spi;
   logic s2_twi;
   logic s2_master;
   logic [4:0] next_pad_out;
   logic [4:0] next_pad_oe_n;
   logic [3:0] next_capture;

   // Each pin has its own four-bit function field.
   assign field_a0 = PORTA_LOW_PIN_CONFIG[pin_mux_pkg::FIELD_A0_LSB +: pin_mux_pkg::FIELD_WIDTH];
   assign field_a1 = PORTA_LOW_PIN_CONFIG[pin_mux_pkg::FIELD_A1_LSB +: pin_mux_pkg::FIELD_WIDTH];
   assign field_a2 = PORTA_LOW_PIN_CONFIG[pin_mux_pkg::FIELD_A2_LSB +: pin_mux_pkg::FIELD_WIDTH];
   assign field_a3 = PORTA_LOW_PIN_CONFIG[pin_mux_pkg::FIELD_A3_LSB +: pin_mux_pkg::FIELD_WIDTH];
   assign field_b4 = PORTB_HIGH_PIN_CONFIG[pin_mux_pkg::FIELD_B4_LSB +: pin_mux_pkg::FIELD_WIDTH];

   // ******************************************************************
   // Timer ownership: a channel claims a pin when enabled and mapped.
   // ******************************************************************
   assign timer_here[0] = TIMER2_CHANNEL_OUTPUT_ENABLE[0]
      && !TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH1];
   assign timer_here[1] = TIMER2_CHANNEL_OUTPUT_ENABLE[2]
      && !TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH3];
   assign timer_here[2] = TIMER2_CHANNEL_OUTPUT_ENABLE[3]
      && !TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH4];
   assign timer_here[3] = TIMER2_CHANNEL_OUTPUT_ENABLE[1]
      && !TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH2];
   assign ch4_on_b4 = TIMER2_CHANNEL_OUTPUT_ENABLE[3]
      && TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH4];

   // ******************************************************************
   // Serial controller modes and roles.
   // ******************************************************************
   assign s1_uart = SERIAL1_PROTOCOL_SELECT == pin_mux_pkg::PROTOCOL_UART;
   assign s1_spi_slave = (SERIAL1_PROTOCOL_SELECT == pin_mux_pkg::PROTOCOL_SPI)
      && !SERIAL1_SPI_CONFIG[pin_mux_pkg::SPI_MASTER_BIT];
   assign s2_spi = SERIAL2_PROTOCOL_SELECT == pin_mux_pkg::PROTOCOL_SPI;
   assign s2_twi = SERIAL2_PROTOCOL_SELECT == pin_mux_pkg::PROTOCOL_TWO_WIRE;
   assign s2_master = SERIAL2_SPI_CONFIG[pin_mux_pkg::SPI_MASTER_BIT];

   // ******************************************************************
   // Pad drive selection.
   // ******************************************************************
   always_comb
   begin
      next_pad_out = pin_mux_pkg::RESET_PAD_OUT;
      next_pad_oe_n = pin_mux_pkg::RESET_PAD_OE_N;
      // Port A pin zero: channel one, else master data out.
      if (is_alt(field_a0))
      begin
         if (timer_here[0])
         begin
            {next_pad_out[0], next_pad_oe_n[0]} = drive(TIMER2_CHANNEL_OUT[0],
               field_a0 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
         else if (s2_spi && s2_master)
         begin
            {next_pad_out[0], next_pad_oe_n[0]} = drive(SERIAL2_MASTER_OUT,
               field_a0 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
      end
      // Port A pin one: channel three, else two-wire data or slave data out.
      if (is_alt(field_a1))
      begin
         if (timer_here[1])
         begin
            {next_pad_out[1], next_pad_oe_n[1]} = drive(TIMER2_CHANNEL_OUT[2],
               field_a1 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
         else if (s2_twi && field_a1 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN)
         begin
            {next_pad_out[1], next_pad_oe_n[1]} = drive(SERIAL2_TWOWIRE_DATA_OUT, 1'b1);
         end
         else if (s2_spi && !s2_master)
         begin
            {next_pad_out[1], next_pad_oe_n[1]} = drive(SERIAL2_SLAVE_OUT,
               field_a1 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
      end
      // Port A pin two: channel four, else two-wire clock or SPI clock.
      if (is_alt(field_a2))
      begin
         if (timer_here[2])
         begin
            {next_pad_out[2], next_pad_oe_n[2]} = drive(TIMER2_CHANNEL_OUT[3],
               field_a2 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
         else if (s2_twi && field_a2 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN)
         begin
            {next_pad_out[2], next_pad_oe_n[2]} = drive(SERIAL2_TWOWIRE_CLOCK_OUT, 1'b1);
         end
         else if (s2_spi && s2_master)
         begin
            {next_pad_out[2], next_pad_oe_n[2]} = drive(SERIAL2_SPI_CLOCK_OUT,
               field_a2 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
      end
      // Port A pin three: channel two, else trace clock.
      if (is_alt(field_a3))
      begin
         if (timer_here[3])
         begin
            {next_pad_out[3], next_pad_oe_n[3]} = drive(TIMER2_CHANNEL_OUT[1],
               field_a3 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
         else if (CPU_TRACE_ENABLE)
         begin
            {next_pad_out[3], next_pad_oe_n[3]} = drive(CPU_TRACE_CLOCK,
               field_a3 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
      end
      // Port B pin four: remapped channel four, else ready-to-send.
      if (is_alt(field_b4))
      begin
         if (ch4_on_b4)
         begin
            {next_pad_out[4], next_pad_oe_n[4]} = drive(TIMER2_CHANNEL_OUT[3],
               field_b4 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
         else if (s1_uart && SERIAL1_UART_CONFIG[pin_mux_pkg::UART_RTS_ENABLE_BIT])
         begin
            {next_pad_out[4], next_pad_oe_n[4]} = drive(SERIAL1_READY_TO_SEND_N,
               field_b4 == pin_mux_pkg::CFG_ALT_OPEN_DRAIN);
         end
      end
      // Pins without an alternate function fall back to the port registers.
      if (!is_alt(field_a0))
      begin
         {next_pad_out[0], next_pad_oe_n[0]} = {GPIO_OUT_DATA[0],
            !(field_a0 == pin_mux_pkg::CFG_GPIO_OUT)};
         if (field_a0 == pin_mux_pkg::CFG_GPIO_OPEN_DRAIN)
         begin
            {next_pad_out[0], next_pad_oe_n[0]} = drive(GPIO_OUT_DATA[0], 1'b1);
         end
      end
      if (!is_alt(field_a1))
      begin
         {next_pad_out[1], next_pad_oe_n[1]} = {GPIO_OUT_DATA[1],
            !(field_a1 == pin_mux_pkg::CFG_GPIO_OUT)};
         if (field_a1 == pin_mux_pkg::CFG_GPIO_OPEN_DRAIN)
         begin
            {next_pad_out[1], next_pad_oe_n[1]} = drive(GPIO_OUT_DATA[1], 1'b1);
         end
      end
      if (!is_alt(field_a2))
      begin
         {next_pad_out[2], next_pad_oe_n[2]} = {GPIO_OUT_DATA[2],
            !(field_a2 == pin_mux_pkg::CFG_GPIO_OUT)};
         if (field_a2 == pin_mux_pkg::CFG_GPIO_OPEN_DRAIN)
         begin
            {next_pad_out[2], next_pad_oe_n[2]} = drive(GPIO_OUT_DATA[2], 1'b1);
         end
      end
      if (!is_alt(field_a3))
      begin
         {next_pad_out[3], next_pad_oe_n[3]} = {GPIO_OUT_DATA[3],
            !(field_a3 == pin_mux_pkg::CFG_GPIO_OUT)};
         if (field_a3 == pin_mux_pkg::CFG_GPIO_OPEN_DRAIN)
         begin
            {next_pad_out[3], next_pad_oe_n[3]} = drive(GPIO_OUT_DATA[3], 1'b1);
         end
      end
      if (!is_alt(field_b4))
      begin
         {next_pad_out[4], next_pad_oe_n[4]} = {GPIO_OUT_DATA[4],
            !(field_b4 == pin_mux_pkg::CFG_GPIO_OUT)};
         if (field_b4 == pin_mux_pkg::CFG_GPIO_OPEN_DRAIN)
         begin
            {next_pad_out[4], next_pad_oe_n[4]} = drive(GPIO_OUT_DATA[4], 1'b1);
         end
      end
   end

   // ******************************************************************
   // Capture sources.
   // ******************************************************************
   always_comb
   begin
      next_capture = TIMER2_REMAPPED_CAPTURE_IN;
      if (!TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH1])
      begin
         next_capture[0] = PAD_IN[pin_mux_pkg::PIN_A0];
      end
      if (!TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH2])
      begin
         next_capture[1] = PAD_IN[pin_mux_pkg::PIN_A3];
      end
      if (!TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH3])
      begin
         next_capture[2] = PAD_IN[pin_mux_pkg::PIN_A1];
      end
      next_capture[3] = TIMER2_REMAP_OPTION[pin_mux_pkg::REMAP_CH4]
         ? PAD_IN[pin_mux_pkg::PIN_B4] : PAD_IN[pin_mux_pkg::PIN_A2];
   end

   // ******************************************************************
   // Registered pad outputs.
   // ******************************************************************
   // Registering costs one cycle of latency, so the trace clock on the pad
   // is a sampled copy and only suits trace clocks well below CLOCK.
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         PAD_OUT <= pin_mux_pkg::RESET_PAD_OUT;
         PAD_OE_N <= pin_mux_pkg::RESET_PAD_OE_N;
      end
      else
      begin
         PAD_OUT <= next_pad_out;
         PAD_OE_N <= next_pad_oe_n;
      end
   end

   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         TIMER2_CAPTURE_IN <= pin_mux_pkg::RESET_CAPTURE;
      end
      else
      begin
         TIMER2_CAPTURE_IN <= next_capture;
      end
   end

   // ******************************************************************
   // Registered serial inputs; idle levels when the role does not apply.
   // ******************************************************************
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         SERIAL1_SLAVE_SELECT_N <= 1'b1;
         SERIAL2_SLAVE_IN <= 1'b0;
         SERIAL2_MASTER_IN <= 1'b0;
         SERIAL2_TWOWIRE_DATA_IN <= 1'b1;
         SERIAL2_TWOWIRE_CLOCK_IN <= 1'b1;
         SERIAL2_SPI_CLOCK_IN <= 1'b0;
         SERIAL2_SLAVE_SELECT_N <= 1'b1;
         GPIO_IN_DATA <= 5'h00;
      end
      else
      begin
         SERIAL1_SLAVE_SELECT_N <= s1_spi_slave ? PAD_IN[pin_mux_pkg::PIN_B4] : 1'b1;
         SERIAL2_SLAVE_IN <= (s2_spi && !s2_master) ? PAD_IN[pin_mux_pkg::PIN_A0] : 1'b0;
         SERIAL2_MASTER_IN <= (s2_spi && s2_master) ? PAD_IN[pin_mux_pkg::PIN_A1] : 1'b0;
         SERIAL2_TWOWIRE_DATA_IN <= s2_twi ? PAD_IN[pin_mux_pkg::PIN_A1] : 1'b1;
         SERIAL2_TWOWIRE_CLOCK_IN <= s2_twi ? PAD_IN[pin_mux_pkg::PIN_A2] : 1'b1;
         SERIAL2_SPI_CLOCK_IN <= (s2_spi && !s2_master) ? PAD_IN[pin_mux_pkg::PIN_A2] : 1'b0;
         SERIAL2_SLAVE_SELECT_N <= (s2_spi && !s2_master) ? PAD_IN[pin_mux_pkg::PIN_A3] : 1'b1;
         GPIO_IN_DATA <= PAD_IN;
      end
   end
endmodule

// ===== tb/pin_mux_monitor.sv
// Concurrent checks on the pad side of the timer and serial pin multiplexer.
`timescale 1ns/1ps
module pin_mux_monitor
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [7:0] TIMER2_REMAP_OPTION,
   input wire logic [3:0] TIMER2_CHANNEL_OUTPUT_ENABLE,
   input wire logic [3:0] PORTB_HIGH_PIN_CONFIG,
   input wire logic [15:0] PORTA_LOW_PIN_CONFIG,
   input wire logic [7:0] SERIAL1_UART_CONFIG,
   input wire logic [1:0] SERIAL1_PROTOCOL_SELECT,
   input wire logic [1:0] SERIAL2_PROTOCOL_SELECT,
   input wire logic CPU_TRACE_ENABLE,
   input wire logic CPU_TRACE_CLOCK,
   input wire logic [3:0] TIMER2_CHANNEL_OUT,
   input wire logic [3:0] TIMER2_CAPTURE_IN,
   input wire logic SERIAL1_READY_TO_SEND_N,
   input wire logic SERIAL2_TWOWIRE_DATA_OUT,
   input wire logic [4:0] PAD_IN,
   input wire logic [4:0] GPIO_IN_DATA,
   input wire logic [4:0] PAD_OUT,
   input wire logic [4:0] PAD_OE_N
);
   // ******************************************************************
   // Field shorthands and the home-pin conditions of channels one, two and three.
   // ******************************************************************
   wire [7:0] rmp = TIMER2_REMAP_OPTION;
   wire [3:0] cce = TIMER2_CHANNEL_OUTPUT_ENABLE;
   wire [15:0] fa = PORTA_LOW_PIN_CONFIG;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   sequence ch1_home;
      !rmp[4] && cce[0] && fa[3:0] == 4'h9;
   endsequence
   sequence ch3_home;
      !rmp[6] && cce[2] && fa[7:4] == 4'h9;
   endsequence
   sequence ch2_home;
      !rmp[5] && cce[1] && fa[15:12] == 4'h9;
   endsequence
   // ******************************************************************
   // Assertions: every pad output lags its cause by exactly one edge.
   // ******************************************************************
   ch4_on_b4_a: assert property (
      rmp[7] && cce[3] && PORTB_HIGH_PIN_CONFIG == 4'h9
      |=> PAD_OUT[4] == $past(TIMER2_CHANNEL_OUT[3]) && !PAD_OE_N[4])
      else $error("channel four not driving B4");
   ch4_capture_a: assert property (
      1'b1 |=> TIMER2_CAPTURE_IN[3] == $past(rmp[7] ? PAD_IN[4] : PAD_IN[2]))
      else $error("channel four capture from wrong pad");
   ch1_home_a: assert property (
      ch1_home |=> PAD_OUT[0] == $past(TIMER2_CHANNEL_OUT[0]) && !PAD_OE_N[0])
      else $error("channel one not on A0");
   ch3_home_a: assert property (
      ch3_home |=> PAD_OUT[1] == $past(TIMER2_CHANNEL_OUT[2]) && !PAD_OE_N[1])
      else $error("channel three not on A1");
   ch2_home_a: assert property (
      ch2_home |=> PAD_OUT[3] == $past(TIMER2_CHANNEL_OUT[1]) && !PAD_OE_N[3])
      else $error("channel two not on A3");
   idle_release_a: assert property (
      fa[3:0] == 4'h9 && !cce[0] && SERIAL2_PROTOCOL_SELECT != 2'h2 |=> PAD_OE_N[0])
      else $error("A0 driven without an owner");
   rts_owner_a: assert property (
      !rmp[7] && SERIAL1_UART_CONFIG[5] && SERIAL1_PROTOCOL_SELECT == 2'h1
      && PORTB_HIGH_PIN_CONFIG == 4'h9
      |=> PAD_OUT[4] == $past(SERIAL1_READY_TO_SEND_N) && !PAD_OE_N[4])
      else $error("ready to send not on B4");
   twowire_drain_a: assert property (
      SERIAL2_PROTOCOL_SELECT == 2'h3 && !cce[2] && fa[7:4] == 4'hd
      |=> !PAD_OUT[1] && PAD_OE_N[1] == $past(SERIAL2_TWOWIRE_DATA_OUT))
      else $error("two-wire data not open drain");
   trace_on_a3_a: assert property (
      CPU_TRACE_ENABLE && !cce[1] && fa[15:12] == 4'h9
      |=> PAD_OUT[3] == $past(CPU_TRACE_CLOCK) && !PAD_OE_N[3])
      else $error("trace clock not on A3");
   gpio_follow_a: assert property (
      1'b1 |=> GPIO_IN_DATA == $past(PAD_IN))
      else $error("pad input not seen one edge later");
endmodule
bind timer_serial_pin_mux pin_mux_monitor u_pin_mux_monitor
(
   .CLOCK(CLOCK), .RESET(RESET), .TIMER2_REMAP_OPTION(TIMER2_REMAP_OPTION),
   .TIMER2_CHANNEL_OUTPUT_ENABLE(TIMER2_CHANNEL_OUTPUT_ENABLE),
   .PORTB_HIGH_PIN_CONFIG(PORTB_HIGH_PIN_CONFIG), .PORTA_LOW_PIN_CONFIG(PORTA_LOW_PIN_CONFIG),
   .SERIAL1_UART_CONFIG(SERIAL1_UART_CONFIG), .SERIAL1_PROTOCOL_SELECT(SERIAL1_PROTOCOL_SELECT),
   .SERIAL2_PROTOCOL_SELECT(SERIAL2_PROTOCOL_SELECT), .CPU_TRACE_ENABLE(CPU_TRACE_ENABLE),
   .CPU_TRACE_CLOCK(CPU_TRACE_CLOCK), .TIMER2_CHANNEL_OUT(TIMER2_CHANNEL_OUT),
   .TIMER2_CAPTURE_IN(TIMER2_CAPTURE_IN), .SERIAL1_READY_TO_SEND_N(SERIAL1_READY_TO_SEND_N),
   .SERIAL2_TWOWIRE_DATA_OUT(SERIAL2_TWOWIRE_DATA_OUT), .PAD_IN(PAD_IN),
   .GPIO_IN_DATA(GPIO_IN_DATA), .PAD_OUT(PAD_OUT), .PAD_OE_N(PAD_OE_N)
);

// ===== tb/board_pads.sv
// Board model: pull-ups and optional external drivers on the five pads.
`timescale 1ns/1ps
module board_pads
(
   input wire logic [4:0] pad_out,
   input wire logic [4:0] pad_oe_n,
   input wire logic [4:0] ext_en,
   input wire logic [4:0] ext_val,
   output logic [4:0] pad_in
);
   // ******************************************************************
   // Pad level.
   // ******************************************************************
   // Every pad has a pull-up, so a released or open-drain high pad reads 1.
   // External drivers only act once the device lets go, which avoids contention.
   always_comb
   begin
      for (int i = 0; i < 5; i++)
      begin
         pad_in[i] = !pad_oe_n[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the timer and serial pin multiplexer.
`timescale 1ns/1ps
module testbench;
   typedef struct packed
   {
      logic [7:0] rmp;
      logic [3:0] cce;
      logic [15:0] cfga;
      logic [3:0] cfgb;
      logic [1:0] s1;
      logic [1:0] s2;
      logic m2;
      logic [3:0] tout;
      logic tr;
      logic [4:0] eo;
      logic [4:0] en;
   } row_t;
   logic clock, reset, m2, tr, s1_ss_n, s2_si, s2_mi, tw_di, tw_ci, s2_ci, s2_ss_n;
   logic [7:0] rmp;
   logic [3:0] cce, cfgb, tout, rcap, cap;
   logic [15:0] cfga;
   logic [1:0] s1, s2;
   logic [4:0] ext_en, ext_val, pad_in, gpio_in, pad_out, pad_oe_n;
   logic rts_n, trc, twd;
   logic [7:0] ucfg, spi1;
   int err_count, n_tests;
   row_t rows [15] = '{
      '{8'h00, 4'hf, 16'h9999, 4'h9, 2'h0, 2'h0, 1'b0, 4'hf, 1'b0, 5'h0f, 5'h10},
      '{8'hf0, 4'hf, 16'h9999, 4'h9, 2'h1, 2'h0, 1'b0, 4'h8, 1'b0, 5'h10, 5'h0f},
      '{8'h00, 4'h8, 16'h0000, 4'h9, 2'h1, 2'h0, 1'b0, 4'hf, 1'b0, 5'h15, 5'h0f},
      '{8'h00, 4'h0, 16'h1111, 4'h1, 2'h0, 2'h0, 1'b0, 4'h0, 1'b0, 5'h15, 5'h00},
      '{8'h00, 4'h0, 16'h9999, 4'h0, 2'h0, 2'h2, 1'b1, 4'h0, 1'b0, 5'h15, 5'h1a},
      '{8'h00, 4'h0, 16'h9999, 4'h0, 2'h0, 2'h2, 1'b0, 4'h0, 1'b0, 5'h12, 5'h1d},
      '{8'h00, 4'h0, 16'h9dd9, 4'h0, 2'h0, 2'h3, 1'b0, 4'h0, 1'b1, 5'h18, 5'h11},
      '{8'h00, 4'h0, 16'h9999, 4'h0, 2'h0, 2'h3, 1'b0, 4'h0, 1'b0, 5'h10, 5'h1f},
      '{8'h00, 4'h0, 16'h9999, 4'h9, 2'h2, 2'h1, 1'b0, 4'h0, 1'b0, 5'h00, 5'h1f},
      '{8'h00, 4'h1, 16'h0009, 4'h0, 2'h0, 2'h2, 1'b1, 4'h0, 1'b0, 5'h14, 5'h1e},
      '{8'h10, 4'h1, 16'h0009, 4'h0, 2'h0, 2'h2, 1'b1, 4'h0, 1'b0, 5'h15, 5'h1e},
      '{8'h80, 4'h8, 16'h0000, 4'h9, 2'h1, 2'h0, 1'b0, 4'h0, 1'b0, 5'h05, 5'h0f},
      '{8'h80, 4'h0, 16'h0000, 4'h9, 2'h1, 2'h0, 1'b0, 4'h8, 1'b0, 5'h15, 5'h0f},
      '{8'h00, 4'h0, 16'h9000, 4'h0, 2'h0, 2'h0, 1'b0, 4'h0, 1'b1, 5'h1d, 5'h17},
      '{8'h00, 4'h0, 16'h0000, 4'h0, 2'h0, 2'h2, 1'b0, 4'h0, 1'b0, 5'h15, 5'h1f}};
   timer_serial_pin_mux u_timer_serial_pin_mux
   (
      .CLOCK(clock), .RESET(reset), .TIMER2_REMAP_OPTION(rmp),
      .TIMER2_CHANNEL_OUTPUT_ENABLE(cce), .PORTB_HIGH_PIN_CONFIG(cfgb),
      .PORTA_LOW_PIN_CONFIG(cfga), .SERIAL1_UART_CONFIG(ucfg), .SERIAL1_PROTOCOL_SELECT(s1),
      .SERIAL2_PROTOCOL_SELECT(s2), .SERIAL1_SPI_CONFIG(spi1),
      .SERIAL2_SPI_CONFIG({3'h0, m2, 4'h0}),
      .CPU_TRACE_ENABLE(tr), .CPU_TRACE_CLOCK(trc), .TIMER2_CHANNEL_OUT(tout),
      .TIMER2_REMAPPED_CAPTURE_IN(rcap), .TIMER2_CAPTURE_IN(cap), .SERIAL1_READY_TO_SEND_N(rts_n),
      .SERIAL1_SLAVE_SELECT_N(s1_ss_n), .SERIAL2_MASTER_OUT(1'b1), .SERIAL2_SLAVE_IN(s2_si),
      .SERIAL2_SLAVE_OUT(1'b1), .SERIAL2_MASTER_IN(s2_mi), .SERIAL2_TWOWIRE_DATA_OUT(twd),
      .SERIAL2_TWOWIRE_DATA_IN(tw_di), .SERIAL2_TWOWIRE_CLOCK_OUT(1'b0),
      .SERIAL2_TWOWIRE_CLOCK_IN(tw_ci), .SERIAL2_SPI_CLOCK_OUT(1'b1), .SERIAL2_SPI_CLOCK_IN(s2_ci),
      .SERIAL2_SLAVE_SELECT_N(s2_ss_n), .GPIO_OUT_DATA(5'h15), .GPIO_IN_DATA(gpio_in),
      .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n)
   );
   board_pads u_board_pads
   (
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
   );
   // ******************************************************************
   // Clock, comparison and stimulus tasks.
   // ******************************************************************
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task chk(input logic [4:0] seen, input logic [4:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Inputs land on one edge, the outputs on the next; sample at the falling edge after.
   task apply(input row_t r);
      @(posedge clock);
      {rmp, cce, cfga, cfgb, s1, s2, m2, tout, tr} <= r[51:10];
      @(posedge clock);
      @(negedge clock);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ******************************************************************
   // Main sequence.
   // ******************************************************************
   initial
   begin
      reset = 1'b1;
      {rmp, cce, cfga, cfgb, s1, s2, m2, tout, tr} = '0;
      {rcap, ext_en, ext_val} = '0;
      {rts_n, trc, twd, ucfg, spi1} = {1'b1, 1'b1, 1'b0, 8'h20, 8'h00};
      err_count = 0;
      n_tests = 0;
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         apply(rows[i]);
         chk(pad_out, rows[i].eo);
         chk(pad_oe_n, rows[i].en);
      end
      // Pads released and driven from the board: captures and slave inputs.
      ext_en <= 5'h1f;
      ext_val <= 5'h15;
      apply(rows[14]);
      chk({1'b0, cap}, 5'h09);
      chk({2'h0, s2_si, s2_ci, s2_ss_n}, 5'h06);
      chk(gpio_in, 5'h15);
      ext_val <= 5'h0a;
      @(posedge clock) rcap <= 4'h5;
      apply('{8'hf0, 4'h0, 16'h0000, 4'h0, 2'h2, 2'h2, 1'b1, 4'h0, 1'b0, 5'h00, 5'h1f});
      chk({1'b0, cap}, 5'h05);
      chk({3'h0, s2_mi, s1_ss_n}, 5'h02);
      // Open-drain high releases the pad; low handshake and trace levels reach their pads.
      @(posedge clock) {rts_n, trc, twd} <= 3'b001;
      apply('{8'h00, 4'h0, 16'h90d0, 4'h9, 2'h1, 2'h3, 1'b0, 4'h0, 1'b1, 5'h05, 5'h07});
      chk(pad_out, 5'h05);
      chk(pad_oe_n, 5'h07);
      chk({3'h0, tw_di, tw_ci}, 5'h02);
      chk(gpio_in, 5'h0a);
      @(posedge clock) ucfg <= 8'h00;
      apply('{8'h00, 4'h0, 16'h90d0, 4'h9, 2'h1, 2'h3, 1'b0, 4'h0, 1'b1, 5'h05, 5'h17});
      chk(pad_oe_n, 5'h17);
      @(posedge clock) spi1 <= 8'h10;
      apply('{8'h00, 4'h0, 16'h0000, 4'h0, 2'h2, 2'h0, 1'b0, 4'h0, 1'b0, 5'h15, 5'h1f});
      chk({4'h0, s1_ss_n}, 5'h01);
      // A second reset in mid-run must release every pad at once.
      apply(rows[0]);
      @(posedge clock);
      reset <= 1'b1;
      @(negedge clock);
      chk(pad_oe_n, pin_mux_pkg::RESET_PAD_OE_N);
      chk(pad_out, pin_mux_pkg::RESET_PAD_OUT);
      @(posedge clock);
      reset <= 1'b0;
      apply(rows[1]);
      chk(pad_out, rows[1].eo);
      wrap_up();
   end
endmodule
